// ### logic/tmc_pkg.sv
// Constants, register map and field layout of the timer channel pin control block
//
// Behaviour
// - Field A zero: compare register, match leaves pin alone; reset value.
// - Field A 001: compare match on register A drives pin low.
// - Field A 010: compare match on register A drives pin high.
// - Field A 011: match toggles pin; channel 2 drives high instead.
// - Field A 100: capture counter into register A on rising pin edge.
// - Field A 101: capture counter into register A on falling pin edge.
// - Field A 11x: capture counter into register A on both pin edges.
// - Bits 6 to 4 give register B the same choices, same encoding.
package tmc_pkg;

    // ------------------------------------------------------------------
    // Register map: printed offsets are word indexes, byte address is 4x
    // ------------------------------------------------------------------
    localparam int          ADDR_W    = 22;
    localparam logic [19:0] IDX_TCR   = 20'hFFF68;
    localparam logic [19:0] IDX_IOC   = 20'hFFF69;
    localparam logic [19:0] IDX_CNT   = 20'hFFF6A;
    localparam logic [19:0] IDX_CPA   = 20'hFFF6C;
    localparam logic [19:0] IDX_CPB   = 20'hFFF6E;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  TCR_RST   = 8'h80;
    localparam logic [7:0]  IOC_RST   = 8'h88;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] GR_RST    = 16'hFFFF;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          IOA_LSB   = 0;
    localparam int          IOB_LSB   = 4;
    localparam int          TPSC_LSB  = 0;
    localparam int          CKEG_LSB  = 3;
    localparam int          CCLR_LSB  = 5;
    localparam logic [7:0]  TCR_WMASK = 8'h7F;
    localparam logic [7:0]  IOC_WMASK = 8'h77;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0]  OUT_NONE  = 2'h0;
    localparam logic [1:0]  OUT_LOW   = 2'h1;
    localparam logic [1:0]  OUT_HIGH  = 2'h2;
    localparam logic [1:0]  OUT_TOGG  = 2'h3;
    localparam logic [1:0]  CLR_NONE  = 2'h0;
    localparam logic [1:0]  CLR_CPA   = 2'h1;
    localparam logic [1:0]  CLR_CPB   = 2'h2;
    localparam logic [1:0]  CLR_SYNC  = 2'h3;
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;
    localparam int          TOGGLE_HIGH_CHANNEL = 2;

endpackage : tmc_pkg

// ### logic/tmc_gr_if.sv
// Interface between the channel core and one general register unit
`timescale 1ns/100ps
`default_nettype none
interface tmc_gr_if;
    logic [2:0]  io_sel;
    logic [15:0] cnt;
    logic        tick;
    logic        wr_en;
    logic [15:0] wr_data;
    logic        pin_in;
    logic [15:0] gr;
    logic        hit;
    logic        pin_out;
    logic        pin_oe;

    modport unit (
        input  io_sel, cnt, tick, wr_en, wr_data, pin_in,
        output gr, hit, pin_out, pin_oe
    );
    modport core (
        output io_sel, cnt, tick, wr_en, wr_data, pin_in,
        input  gr, hit, pin_out, pin_oe
    );
endinterface : tmc_gr_if
`default_nettype wire

// ### logic/tmc_gr_unit.sv
// One general register working as output compare or input capture register
`timescale 1ns/100ps
`default_nettype none
module tmc_gr_unit
    import tmc_pkg::*;
#(
    parameter int CHANNEL = 0
) (
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    // Link to the core
    tmc_gr_if.unit     bus
);

    // ------------------------------------------------------------------
    // Mode decode and pin edges
    // ------------------------------------------------------------------
    logic        pin_prev_q;
    logic [15:0] gr_q;
    logic        pin_out_q;
    logic        pin_oe_q;
    logic        pin_out_d;

    wire         is_capture = bus.io_sel[2];
    wire  [1:0]  out_mode   = bus.io_sel[1:0];
    wire         pin_rise   = bus.pin_in & ~pin_prev_q;
    wire         pin_fall   = ~bus.pin_in & pin_prev_q;
    wire         edge_both  = pin_rise | pin_fall;
    wire         edge_one   = bus.io_sel[0] ? pin_fall : pin_rise;
    wire         cap_hit    = is_capture & (bus.io_sel[1] ? edge_both : edge_one);
    wire         cmp_hit    = ~is_capture & bus.tick & (bus.cnt == gr_q);
    wire         toggle_hi  = (CHANNEL == TOGGLE_HIGH_CHANNEL);

    // Capture beats a software write in the same cycle
    wire  [15:0] gr_d = cap_hit ? bus.cnt : (bus.wr_en ? bus.wr_data : gr_q);

    // ------------------------------------------------------------------
    // Compare output action
    // ------------------------------------------------------------------
    always_comb begin
        pin_out_d = pin_out_q;
        if (cmp_hit) begin
            case (out_mode)
                OUT_NONE: pin_out_d = pin_out_q;
                OUT_LOW:  pin_out_d = 1'b0;
                OUT_HIGH: pin_out_d = 1'b1;
                OUT_TOGG: pin_out_d = toggle_hi ? 1'b1 : ~pin_out_q;
                default:  pin_out_d = pin_out_q;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_prev_q <= 1'b0;
            gr_q       <= GR_RST;
            pin_out_q  <= 1'b0;
            pin_oe_q   <= 1'b0;
        end else begin
            pin_prev_q <= bus.pin_in;
            gr_q       <= gr_d;
            pin_out_q  <= pin_out_d;
            pin_oe_q   <= ~is_capture & (out_mode != OUT_NONE);
        end
    end

    assign bus.gr      = gr_q;
    assign bus.hit     = cmp_hit | cap_hit;
    assign bus.pin_out = pin_out_q;
    assign bus.pin_oe  = pin_oe_q;

endmodule : tmc_gr_unit
`default_nettype wire

// ### logic/tmc_timer_channel.sv
// 16-bit timer channel with compare/capture pin control and AXI4-Lite registers
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module tmc_timer_channel
    import tmc_pkg::*;
#(
    parameter int CHANNEL = 0
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // External count clock pins A to D
    input  wire logic [3:0]        ext_clk_in,
    // Synchronous clear from a neighbouring channel
    input  wire logic              sync_clear_in,
    // Timer pin of general register A
    input  wire logic              pin_a_in,
    output logic                   pin_a_out,
    output logic                   pin_a_oe,
    // Timer pin of general register B
    input  wire logic              pin_b_in,
    output logic                   pin_b_out,
    output logic                   pin_b_oe
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  tcr_q;
    logic [7:0]  ioc_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [2:0]  div_q;
    logic        ext_prev_q;

    // ------------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] wr_addr_q;
    logic [31:0]       wr_data_q;
    logic [3:0]        wr_strb_q;
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    wire        aw_take   = s_axi_awvalid & awready_q;
    wire        w_take    = s_axi_wvalid & wready_q;
    wire        wr_fire   = ~awready_q & ~wready_q & ~bvalid_q;
    wire [19:0] wr_idx    = wr_addr_q[ADDR_W-1:2];
    wire        wr_tcr    = wr_fire & (wr_idx == IDX_TCR);
    wire        wr_ioc    = wr_fire & (wr_idx == IDX_IOC);
    wire        wr_cnt    = wr_fire & (wr_idx == IDX_CNT);
    wire        wr_cpa    = wr_fire & (wr_idx == IDX_CPA);
    wire        wr_cpb    = wr_fire & (wr_idx == IDX_CPB);
    wire        wr_hit    = wr_tcr | wr_ioc | wr_cnt | wr_cpa | wr_cpb;
    wire [15:0] wr_mask16 = {{8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};
    wire [7:0]  wr_mask8  = {8{wr_strb_q[0]}};
    wire [7:0]  tcr_keep  = tcr_q & ~(wr_mask8 & TCR_WMASK);
    wire [7:0]  ioc_keep  = ioc_q & ~(wr_mask8 & IOC_WMASK);
    wire [7:0]  tcr_new   = tcr_keep | (wr_data_q[7:0] & wr_mask8 & TCR_WMASK);
    wire [7:0]  ioc_new   = ioc_keep | (wr_data_q[7:0] & wr_mask8 & IOC_WMASK);
    wire [15:0] cnt_new   = (cnt_q & ~wr_mask16) | (wr_data_q[15:0] & wr_mask16);

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    tmc_gr_if gr_bus [2] ();

    wire        ar_take   = s_axi_arvalid & arready_q;
    wire [19:0] rd_idx    = s_axi_araddr[ADDR_W-1:2];
    wire        rd_tcr    = (rd_idx == IDX_TCR);
    wire        rd_ioc    = (rd_idx == IDX_IOC);
    wire        rd_cnt    = (rd_idx == IDX_CNT);
    wire        rd_cpa    = (rd_idx == IDX_CPA);
    wire        rd_cpb    = (rd_idx == IDX_CPB);
    wire        rd_hit    = rd_tcr | rd_ioc | rd_cnt | rd_cpa | rd_cpb;
    wire [15:0] cpa_val   = gr_bus[0].gr;
    wire [15:0] cpb_val   = gr_bus[1].gr;
    wire [31:0] rd_word   = rd_tcr ? {24'h000000, tcr_q} :
                            rd_ioc ? {24'h000000, ioc_q} :
                            rd_cnt ? {16'h0000, cnt_q}   :
                            rd_cpa ? {16'h0000, cpa_val} :
                            rd_cpb ? {16'h0000, cpb_val} : 32'h00000000;

    // ------------------------------------------------------------------
    // Count clock selection
    // ------------------------------------------------------------------
    wire [2:0]  clk_sel   = tcr_q[TPSC_LSB+2:TPSC_LSB];
    wire [1:0]  edge_sel  = tcr_q[CKEG_LSB+1:CKEG_LSB];
    wire [1:0]  clr_sel   = tcr_q[CCLR_LSB+1:CCLR_LSB];
    wire        ext_level = ext_clk_in[clk_sel[1:0]];
    wire        ext_rise  = ext_level & ~ext_prev_q;
    wire        ext_fall  = ~ext_level & ext_prev_q;
    wire        ext_one   = edge_sel[0] ? ext_fall : ext_rise;
    wire        ext_tick  = edge_sel[1] ? (ext_rise | ext_fall) : ext_one;
    wire        div2_en   = div_q[0];
    wire        div4_en   = &div_q[1:0];
    wire        div8_en   = &div_q;
    wire        int_tick  = (clk_sel[1:0] == 2'h0) ? 1'b1    :
                            (clk_sel[1:0] == 2'h1) ? div2_en :
                            (clk_sel[1:0] == 2'h2) ? div4_en : div8_en;
    wire        cnt_tick  = clk_sel[2] ? ext_tick : int_tick;

    // ------------------------------------------------------------------
    // Counter clear source
    // ------------------------------------------------------------------
    wire        hit_a     = gr_bus[0].hit;
    wire        hit_b     = gr_bus[1].hit;
    wire        clr_hit   = ((clr_sel == CLR_CPA) & hit_a) |
                            ((clr_sel == CLR_CPB) & hit_b) |
                            ((clr_sel == CLR_SYNC) & sync_clear_in);

    always_comb begin
        cnt_d = cnt_q;
        if (wr_cnt) begin
            cnt_d = cnt_new;
        end else if (clr_hit) begin
            cnt_d = CNT_RST;
        end else if (cnt_tick) begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // General register units A and B
    // ------------------------------------------------------------------
    wire [1:0]  gr_wr   = {wr_cpb, wr_cpa};
    wire [1:0]  gr_pin  = {pin_b_in, pin_a_in};
    wire [5:0]  gr_sel  = {ioc_q[IOB_LSB+2:IOB_LSB], ioc_q[IOA_LSB+2:IOA_LSB]};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_gr
            assign gr_bus[gi].io_sel  = gr_sel[3*gi +: 3];
            assign gr_bus[gi].cnt     = cnt_q;
            assign gr_bus[gi].tick    = cnt_tick;
            assign gr_bus[gi].wr_en   = gr_wr[gi];
            assign gr_bus[gi].wr_data = cnt_new & wr_mask16 | wr_data_q[15:0] & wr_mask16
                                        | (gr_bus[gi].gr & ~wr_mask16);
            assign gr_bus[gi].pin_in  = gr_pin[gi];

            tmc_gr_unit #(
                .CHANNEL (CHANNEL)
            ) u_gr (
                .mclk    (mclk),
                .sys_rst (sys_rst),
                .bus     (gr_bus[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Timer state
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tcr_q      <= TCR_RST;
            ioc_q      <= IOC_RST;
            cnt_q      <= CNT_RST;
            div_q      <= 3'h0;
            ext_prev_q <= 1'b0;
        end else begin
            tcr_q      <= wr_tcr ? tcr_new : tcr_q;
            ioc_q      <= wr_ioc ? ioc_new : ioc_q;
            cnt_q      <= cnt_d;
            div_q      <= div_q + 3'h1;
            ext_prev_q <= ext_level;
        end
    end

    // ------------------------------------------------------------------
    // Write channel handshake
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OK;
            wr_addr_q <= '0;
            wr_data_q <= 32'h00000000;
            wr_strb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                awready_q <= 1'b0;
                wr_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wready_q  <= 1'b0;
                wr_data_q <= s_axi_wdata;
                wr_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? RESP_OK : RESP_ERR;
            end
            if (bvalid_q & s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read channel handshake
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= RESP_OK;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= rd_hit ? RESP_OK : RESP_ERR;
        end else if (rvalid_q & s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign pin_a_out     = gr_bus[0].pin_out;
    assign pin_a_oe      = gr_bus[0].pin_oe;
    assign pin_b_out     = gr_bus[1].pin_out;
    assign pin_b_oe      = gr_bus[1].pin_oe;

endmodule : tmc_timer_channel
`default_nettype wire

// ### verification/tmc_assertions.sv
// Concurrent checks on the ports of the timer channel
`timescale 1ns/100ps
`default_nettype none
module tmc_chk
    import tmc_pkg::*;
(
    // Clock and reset
    input wire logic              mclk,
    input wire logic              sys_rst,
    // Register bus
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // Timer pins
    input wire logic              pin_a_out,
    input wire logic              pin_a_oe,
    input wire logic              pin_b_out,
    input wire logic              pin_b_oe
);
    logic [ADDR_W-1:0] ar_q;
    logic              ar_hit;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Address of the read in flight, to judge its answer
    always_ff @(posedge mclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ar_q <= s_axi_araddr;
        end
    end
    assign ar_hit = (ar_q[1:0] == 2'h0)
                 && (ar_q[ADDR_W-1:2] inside {IDX_TCR, IDX_IOC, IDX_CNT, IDX_CPA, IDX_CPB});

    rd_after_ar_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read answer not one cycle after address");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped before taken");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped before taken");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted while answer pending");
    bad_addr_a: assert property (s_axi_rvalid && !ar_hit
        |-> s_axi_rdata == 32'h0 && s_axi_rresp == RESP_ERR) else $error("unmapped read not refused");
    good_addr_a: assert property (s_axi_rvalid && ar_hit |-> s_axi_rresp == RESP_OK)
        else $error("mapped read refused");
    ioc_fixed_a: assert property (s_axi_rvalid && ar_q == {IDX_IOC, 2'h0}
        |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[7] && s_axi_rdata[3])
        else $error("pin control fixed bits wrong");
    pin_a_quiet_a: assert property (!pin_a_oe && !$past(pin_a_oe) |-> $stable(pin_a_out))
        else $error("undriven pin A changed");
    pin_b_quiet_a: assert property (!pin_b_oe && !$past(pin_b_oe) |-> $stable(pin_b_out))
        else $error("undriven pin B changed");
    oe_after_wr_a: assert property ($changed(pin_a_oe) |-> $past(s_axi_bvalid))
        else $error("pin A enable moved without a write");

    cov_err_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_ERR);
    cov_high_c: cover property ($rose(pin_b_out));
    cov_low_c: cover property ($fell(pin_a_out));
endmodule : tmc_chk

bind tmc_timer_channel tmc_chk u_chk (.mclk, .sys_rst, .s_axi_awready, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_a_out, .pin_a_oe,
    .pin_b_out, .pin_b_oe);
`default_nettype wire

// ### verification/tmc_pin_model.sv
// Behavioural model of the levels outside the timer pins
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_model (
    // Clock
    input wire logic  mclk,
    // Drive from the channel
    input wire logic  pin_a_out,
    input wire logic  pin_a_oe,
    input wire logic  pin_b_out,
    input wire logic  pin_b_oe,
    // Levels seen by the channel
    output logic       pin_a_in,
    output logic       pin_b_in,
    output logic [3:0] ext_clk_in,
    output logic       sync_clear_in
);
    logic lvl_a = 1'b0;
    logic lvl_b = 1'b0;

    // A driven pin reads back its own drive level
    assign pin_a_in = pin_a_oe ? pin_a_out : lvl_a;
    assign pin_b_in = pin_b_oe ? pin_b_out : lvl_b;

    initial begin
        ext_clk_in    = 4'h0;
        sync_clear_in = 1'b0;
    end

    task automatic set_pins(input logic a, input logic b);
        @(posedge mclk);
        lvl_a <= a;
        lvl_b <= b;
        repeat (4) @(posedge mclk);
    endtask : set_pins

    // Whole pulses only, so the line rests low between bursts
    task automatic pulse_ext(input int sel, input int n);
        repeat (n) begin
            @(posedge mclk);
            ext_clk_in[sel] <= 1'b1;
            repeat (3) @(posedge mclk);
            ext_clk_in[sel] <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask : pulse_ext
endmodule : tmc_pin_model
`default_nettype wire

// ### verification/timer_channel_io_control_tb_top.sv
// Self-checking bench for the timer channel pin control block
`timescale 1ns/100ps
`default_nettype none
module timer_channel_io_control_tb_top
    import tmc_pkg::*;
;
    localparam logic [21:0] A_TCR = {IDX_TCR, 2'h0};
    localparam logic [21:0] A_IOC = {IDX_IOC, 2'h0};
    localparam logic [21:0] A_CNT = {IDX_CNT, 2'h0};
    localparam logic [21:0] A_CPA = {IDX_CPA, 2'h0};
    localparam logic [21:0] A_CPB = {IDX_CPB, 2'h0};

    logic        mclk;
    logic        sys_rst = 1'b1;
    logic [21:0] s_axi_awaddr = 22'h0, s_axi_araddr = 22'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF, ext_clk_in;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        sync_clear_in, pin_a_in, pin_a_out, pin_a_oe, pin_b_in, pin_b_out, pin_b_oe;
    logic [55:0] exp_q[$];
    logic [55:0] ent;
    int          mismatches = 0;
    int          n_checks = 0;

    tmc_timer_channel #(.CHANNEL(0)) DUT (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clk_in, .sync_clear_in, .pin_a_in,
        .pin_a_out, .pin_a_oe, .pin_b_in, .pin_b_out, .pin_b_oe);
    tmc_pin_model pm (.mclk, .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe, .pin_a_in,
        .pin_b_in, .ext_clk_in, .sync_clear_in);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic stuck();
        mismatches++;
        $display("[ERR] handshake expected done seen stuck");
        finish_test();
    endtask : stuck

    task automatic wr(input logic [21:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int   n;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tb = 1'b0;
        for (n = 0; n < 40 && !tb; n++) begin
            @(negedge mclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = (s_axi_bvalid === 1'b1);
            if (tb) chk("bresp", 34'(RESP_OK), 34'(s_axi_bresp));
            @(posedge mclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (!tb) stuck();
    endtask : wr

    // Expected answer is queued; the monitor below compares it
    task automatic rd(input logic [21:0] a, input logic [33:0] e);
        logic ta, tr;
        int   n;
        exp_q.push_back({a, e});
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tr = 1'b0;
        for (n = 0; n < 40 && !tr; n++) begin
            @(negedge mclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = (s_axi_rvalid === 1'b1);
            @(posedge mclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (!tr) stuck();
    endtask : rd

    always @(negedge mclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            ent = exp_q.pop_front();
            chk($sformatf("read %h", ent[55:34]), ent[33:0], {s_axi_rresp, s_axi_rdata});
        end
    end

    initial begin
        logic [2:0]  cmp_m[5];
        logic [2:0]  m;
        logic [15:0] g, v, e;
        logic        pin_e;
        int          k, n;
        cmp_m = '{3'h2, 3'h0, 3'h1, 3'h3, 3'h3};
        void'($urandom(30));
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(A_TCR, 34'(TCR_RST));
        rd(A_IOC, 34'(IOC_RST));
        rd(A_CPA, 34'(GR_RST));
        rd(A_CPB, 34'(GR_RST));
        rd(22'h0, {RESP_ERR, 32'h0});
        chk("pin oe", 34'(2'h0), 34'({pin_a_oe, pin_b_oe}));
        $display("test reset done");
        pin_e = 1'b0;
        foreach (cmp_m[i]) begin
            m = cmp_m[i];
            g = 16'($urandom_range(300, 100));
            wr(A_CPA, 32'(g));
            wr(A_CPB, 32'(g));
            wr(A_IOC, 32'({1'b0, m, 1'b0, m}));
            wr(A_CNT, 32'h0);
            repeat (320) @(posedge mclk);
            pin_e = (m == 3'h1) ? 1'b0 : (m == 3'h2) ? 1'b1 : (m == 3'h3) ? !pin_e : pin_e;
            chk("pin_a_out", 34'(pin_e), 34'(pin_a_out));
            chk("pin_b_out", 34'(pin_e), 34'(pin_b_out));
            chk("pin_a_oe", 34'(m != 3'h0), 34'(pin_a_oe));
            rd(A_IOC, 34'(IOC_RST | {1'b0, m, 1'b0, m}));
        end
        $display("test compare done");
        wr(A_TCR, 32'h24);
        for (k = 4; k < 8; k++) begin
            m = 3'(k);
            v = 16'($urandom());
            wr(A_IOC, 32'({1'b0, m, 1'b0, m}));
            wr(A_CPA, 32'h0);
            wr(A_CPB, 32'h0);
            wr(A_CNT, 32'(v));
            pm.set_pins(1'b1, 1'b1);
            e = (m == 3'h5) ? 16'h0 : v;
            rd(A_CPA, 34'(e));
            rd(A_CPB, 34'(e));
            rd(A_CNT, 34'(v ^ e));
            v = 16'($urandom());
            wr(A_CNT, 32'(v));
            pm.set_pins(1'b0, 1'b0);
            e = (m == 3'h4) ? e : v;
            rd(A_CPA, 34'(e));
            rd(A_CPB, 34'(e));
        end
        $display("test capture done");
        for (k = 0; k < 4; k++) begin
            n = $urandom_range(5, 1);
            wr(A_TCR, 32'({k[1:0], 1'b1, k[1:0]}));
            wr(A_CNT, 32'h0);
            pm.pulse_ext(k, n);
            rd(A_CNT, 34'((k > 1) ? 2 * n : n));
        end
        $display("test count done");
        finish_test();
    end
endmodule : timer_channel_io_control_tb_top
`default_nettype wire
